// ---- sbju_pkg.sv ----
// constants and types shared by the signed branch and jump unit
package sbju_pkg;

    // ==========================================================
    // opcodes
    localparam logic [7:0] SBJU_OP_JLESS = 8'h7C;
    localparam logic [7:0] SBJU_OP_JLEQ = 8'h7E;
    localparam logic [7:0] SBJU_OP_JSHORT = 8'hEB;
    localparam logic [7:0] SBJU_OP_JNEAR = 8'hE9;
    localparam logic [7:0] SBJU_OP_JFAR = 8'hEA;
    localparam logic [7:0] SBJU_OP_GRP = 8'hFF;
    localparam logic [2:0] SBJU_REG_NEAR_IND = 3'h4;
    localparam logic [2:0] SBJU_REG_FAR_IND = 3'h5;

    // ==========================================================
    // sign extension
    localparam logic [15:0] SBJU_SEXT_NEG = 16'hFF00;
    localparam logic [15:0] SBJU_SEXT_POS = 16'h00FF;

    // ==========================================================
    // cycle counts, total clocks per instruction
    localparam logic [5:0] SBJU_CYC_COND_TAKEN = 6'd13;
    localparam logic [5:0] SBJU_CYC_COND_NOT = 6'd4;
    localparam logic [5:0] SBJU_CYC_JSHORT = 6'd14;
    localparam logic [5:0] SBJU_CYC_JNEAR = 6'd14;
    localparam logic [5:0] SBJU_CYC_NEAR_REG = 6'd11;
    localparam logic [5:0] SBJU_CYC_NEAR_MEM16 = 6'd17;
    localparam logic [5:0] SBJU_CYC_NEAR_MEM8 = 6'd21;
    localparam logic [5:0] SBJU_CYC_JFAR = 6'd14;
    localparam logic [5:0] SBJU_CYC_FAR_IND16 = 6'd26;
    localparam logic [5:0] SBJU_CYC_FAR_IND8 = 6'd34;

    // ==========================================================
    // reset values
    localparam logic [15:0] SBJU_RST_IP = 16'h0000;
    localparam logic [15:0] SBJU_RST_CS = 16'h0000;

    typedef enum logic [2:0] {
        SBJU_ST_IDLE = 3'b001,
        SBJU_ST_BUSY = 3'b010,
        SBJU_ST_DONE = 3'b100
    } sbju_state_t;

    // resolved action of one instruction
    typedef struct packed {
        logic valid;
        logic load_cs;
        logic taken;
        logic [15:0] ip;
        logic [15:0] cs;
        logic [5:0] cycles;
    } sbju_result_t;

endpackage : sbju_pkg

// ---- sbju_res_if.sv ----
// carrier of a resolved jump from the decoder to the sequencer
`timescale 1ns/1ps
interface sbju_res_if;
    import sbju_pkg::*;
    sbju_result_t res;
    modport src (output res);
    modport dst (input res);
endinterface : sbju_res_if

// ---- sbju_decode.sv ----
// combinational resolution of opcode, flags and operands into a target
`timescale 1ns/1ps
module sbju_decode
    import sbju_pkg::*;
(
    input wire logic i_valid, // instruction present
    input wire logic [7:0] i_opcode, // opcode byte
    input wire logic [2:0] i_reg_field, // modrm reg field
    input wire logic i_rm_is_reg, // near indirect operand in a register
    input wire logic i_bus8, // 8-bit bus variant
    input wire logic i_sign_flag, // sign flag
    input wire logic i_overflow_flag, // overflow flag
    input wire logic i_zero_flag, // zero flag
    input wire logic [15:0] i_next_ip, // address of the following instruction
    input wire logic [15:0] i_cur_cs, // current code segment
    input wire logic [15:0] i_imm16, // rel16 or ptr offset or rel8 in low byte
    input wire logic [15:0] i_imm_seg, // ptr16:16 segment word
    input wire logic [15:0] i_opnd_off, // r/m16 or m16:16 offset word
    input wire logic [15:0] i_opnd_seg, // m16:16 segment word
    sbju_res_if.src res_o // resolved action
);

    function automatic logic [15:0] sbju_sext8(input logic [7:0] d);
        sbju_sext8 = d[7] ? (SBJU_SEXT_NEG | {8'h00, d}) : (SBJU_SEXT_POS & {8'h00, d});
    endfunction

    // 16-bit target, carry dropped so the pointer wraps in the segment
    function automatic logic [15:0] sbju_add16(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        sbju_add16 = s[15:0];
    endfunction

    sbju_result_t r;
    logic lt;

    always_comb begin
        lt = i_sign_flag ^ i_overflow_flag;
        r = '0;
        r.ip = i_next_ip;
        r.cs = i_cur_cs;
        r.valid = i_valid;
        unique case (i_opcode)
            SBJU_OP_JLESS: begin
                r.taken = lt;
            end
            SBJU_OP_JLEQ: begin
                r.taken = lt | i_zero_flag;
            end
            SBJU_OP_JSHORT, SBJU_OP_JNEAR, SBJU_OP_JFAR: begin
                r.taken = 1'b1;
            end
            SBJU_OP_GRP: begin
                r.taken = (i_reg_field == SBJU_REG_NEAR_IND) ||
                          (i_reg_field == SBJU_REG_FAR_IND);
            end
            default: begin
                r.valid = 1'b0;
            end
        endcase
        unique case (i_opcode)
            SBJU_OP_JLESS, SBJU_OP_JLEQ: begin
                r.cycles = r.taken ? SBJU_CYC_COND_TAKEN : SBJU_CYC_COND_NOT;
                if (r.taken) begin
                    r.ip = sbju_add16(i_next_ip, sbju_sext8(i_imm16[7:0]));
                end
                // not taken: ip stays at the next instruction
            end
            SBJU_OP_JSHORT: begin
                r.ip = sbju_add16(i_next_ip, sbju_sext8(i_imm16[7:0]));
                r.cycles = SBJU_CYC_JSHORT;
            end
            SBJU_OP_JNEAR: begin
                r.ip = sbju_add16(i_next_ip, i_imm16);
                r.cycles = SBJU_CYC_JNEAR;
            end
            SBJU_OP_JFAR: begin
                r.ip = i_imm16;
                r.cs = i_imm_seg;
                r.load_cs = 1'b1;
                r.cycles = SBJU_CYC_JFAR;
            end
            SBJU_OP_GRP: begin
                if (i_reg_field == SBJU_REG_NEAR_IND) begin
                    r.ip = i_opnd_off;
                    r.cycles = i_rm_is_reg ? SBJU_CYC_NEAR_REG :
                               (i_bus8 ? SBJU_CYC_NEAR_MEM8 : SBJU_CYC_NEAR_MEM16);
                end else if (i_reg_field == SBJU_REG_FAR_IND) begin
                    r.ip = i_opnd_off;
                    r.cs = i_opnd_seg;
                    r.load_cs = 1'b1;
                    r.cycles = i_bus8 ? SBJU_CYC_FAR_IND8 : SBJU_CYC_FAR_IND16;
                end else begin
                    r.valid = 1'b0;
                end
            end
            default: begin
                r.cycles = '0;
            end
        endcase
        // short and near forms keep the segment
        if (!r.load_cs) begin
            r.cs = i_cur_cs;
        end
        res_o.res = r;
    end

endmodule // sbju_decode

// ---- sbju_top.sv ----
// signed branch and jump unit: resolves 7C/7E/EB/E9/EA/FF/4/FF/5 with clock timing
`timescale 1ns/1ps
module sbju_top
    import sbju_pkg::*;
(
    input wire logic i_clk, // core clock, 25 MHz
    input wire logic i_rst_n, // synchronous reset, active low
    input wire logic i_start, // pulse: execute the presented instruction
    input wire logic [7:0] i_opcode, // opcode byte
    input wire logic [2:0] i_reg_field, // modrm reg field
    input wire logic i_rm_is_reg, // near indirect operand is a register
    input wire logic i_bus8, // 8-bit bus variant
    input wire logic i_sign_flag, // sign flag
    input wire logic i_overflow_flag, // overflow flag
    input wire logic i_zero_flag, // zero flag
    input wire logic [15:0] i_next_ip, // address of the following instruction
    input wire logic [15:0] i_cur_cs, // current code segment
    input wire logic [15:0] i_imm16, // immediate offset or displacement
    input wire logic [15:0] i_imm_seg, // immediate segment word
    input wire logic [15:0] i_opnd_off, // fetched offset word
    input wire logic [15:0] i_opnd_seg, // fetched segment word
    output logic o_busy, // instruction in progress
    output logic o_ready, // can accept i_start
    output logic o_done, // pulse: result valid
    output logic o_illegal, // pulse: opcode not handled
    output logic o_taken, // branch was taken
    output logic o_load_cs, // code segment is loaded
    output logic [15:0] o_instruction_pointer, // new instruction pointer
    output logic [15:0] o_code_segment, // new code segment
    output logic o_push_return // always low, no return info
);

    // ==========================================================
    // state
    typedef struct packed {
        sbju_state_t st;
        logic [5:0] cnt;
        logic taken;
        logic load_cs;
        logic illegal;
        logic [15:0] ip;
        logic [15:0] cs;
    } sbju_regs_t;

    sbju_regs_t q, d;
    sbju_res_if res_bus ();

    // ==========================================================
    // decode
    sbju_decode u_decode (
        .i_valid(i_start),
        .i_opcode(i_opcode),
        .i_reg_field(i_reg_field),
        .i_rm_is_reg(i_rm_is_reg),
        .i_bus8(i_bus8),
        .i_sign_flag(i_sign_flag),
        .i_overflow_flag(i_overflow_flag),
        .i_zero_flag(i_zero_flag),
        .i_next_ip(i_next_ip),
        .i_cur_cs(i_cur_cs),
        .i_imm16(i_imm16),
        .i_imm_seg(i_imm_seg),
        .i_opnd_off(i_opnd_off),
        .i_opnd_seg(i_opnd_seg),
        .res_o(res_bus.src)
    );

    // ==========================================================
    // sequencer: holds the result until the clock count runs out
    always_comb begin
        d = q;
        d.illegal = 1'b0;
        unique case (q.st)
            SBJU_ST_IDLE: begin
                if (i_start) begin
                    if (res_bus.res.valid) begin
                        d.taken = res_bus.res.taken;
                        d.load_cs = res_bus.res.load_cs;
                        d.ip = res_bus.res.ip;
                        d.cs = res_bus.res.cs;
                        // start cycle counts as the first clock
                        d.cnt = res_bus.res.cycles - 6'd1;
                        d.st = (d.cnt == 6'd1) ? SBJU_ST_DONE : SBJU_ST_BUSY;
                    end else begin
                        d.illegal = 1'b1;
                    end
                end
            end
            SBJU_ST_BUSY: begin
                d.cnt = q.cnt - 6'd1;
                if (q.cnt == 6'd2) begin
                    d.st = SBJU_ST_DONE;
                end
            end
            SBJU_ST_DONE: begin
                d.cnt = '0;
                d.st = SBJU_ST_IDLE;
            end
            default: begin
                d.st = SBJU_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            q.st <= SBJU_ST_IDLE;
            q.cnt <= '0;
            q.taken <= 1'b0;
            q.load_cs <= 1'b0;
            q.illegal <= 1'b0;
            q.ip <= SBJU_RST_IP;
            q.cs <= SBJU_RST_CS;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // outputs
    assign o_busy = (q.st != SBJU_ST_IDLE);
    assign o_ready = (q.st == SBJU_ST_IDLE);
    assign o_done = (q.st == SBJU_ST_DONE);
    assign o_illegal = q.illegal;
    assign o_taken = q.taken;
    assign o_load_cs = q.load_cs;
    assign o_instruction_pointer = q.ip;
    assign o_code_segment = q.cs;
    assign o_push_return = 1'b0;

endmodule // sbju_top

// ---- sbju_properties.sv ----
// checker of the signed branch and jump unit ports
`timescale 1ns/1ps
module sbju_properties
    import sbju_pkg::*;
(
    input wire logic i_clk, // clock
    input wire logic i_rst_n, // reset
    input wire logic i_start, // start
    input wire logic [7:0] i_opcode, // opcode
    input wire logic i_sign_flag, // sign
    input wire logic i_overflow_flag, // overflow
    input wire logic i_zero_flag, // zero
    input wire logic [15:0] i_next_ip, // next address
    input wire logic [15:0] i_imm16, // immediate
    input wire logic [15:0] i_imm_seg, // segment word
    input wire logic o_ready, // idle
    input wire logic o_done, // end pulse
    input wire logic o_taken, // taken
    input wire logic o_load_cs, // segment load
    input wire logic [15:0] o_instruction_pointer, // pointer
    input wire logic [15:0] o_code_segment, // segment
    input wire logic o_push_return // return save
);
    // ==========
    // relations at the ports
    logic acc, lt, cnd, tk;
    logic [15:0] tgt, tgt16, cond_ip;
    assign acc = i_start && o_ready;
    assign lt = i_sign_flag != i_overflow_flag;
    assign cnd = acc && (i_opcode == SBJU_OP_JLESS || i_opcode == SBJU_OP_JLEQ);
    assign tk = lt || (i_opcode == SBJU_OP_JLEQ && i_zero_flag);
    // upper byte of the word must not leak into a short target
    assign tgt = i_next_ip + {{8{i_imm16[7]}}, i_imm16[7:0]};
    // near offset is a whole word, carry dropped
    assign tgt16 = i_next_ip + i_imm16;
    assign cond_ip = tk ? tgt : i_next_ip;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_end; o_done ##1 o_ready; endsequence
    property p_less; acc && i_opcode == SBJU_OP_JLESS |=> o_taken == $past(lt); endproperty
    a_less: assert property (p_less) else $error("less test wrong");
    property p_leq; acc && i_opcode == SBJU_OP_JLEQ |=> o_taken == $past(tk); endproperty
    a_leq: assert property (p_leq) else $error("less-equal test wrong");
    property p_cond_tgt;
        cnd |=> !o_load_cs && o_instruction_pointer == $past(cond_ip);
    endproperty
    a_cond_tgt: assert property (p_cond_tgt) else $error("bad ip");
    property p_cond_slow; cnd && tk |-> ##1 (!o_done) [*8] ##1 (!o_done) [*3] ##1 s_end; endproperty
    a_cond_slow: assert property (p_cond_slow) else $error("taken length wrong");
    property p_cond_fast; cnd && !tk |-> ##1 (!o_done) [*2] ##1 s_end; endproperty
    a_cond_fast: assert property (p_cond_fast) else $error("untaken length wrong");
    property p_short;
        acc && i_opcode == SBJU_OP_JSHORT |=>
            (o_instruction_pointer == $past(tgt) && !o_load_cs) ##12 s_end;
    endproperty
    a_short: assert property (p_short) else $error("short jump wrong");
    property p_near;
        acc && i_opcode == SBJU_OP_JNEAR |=>
            (o_instruction_pointer == $past(tgt16) && !o_load_cs) ##12 s_end;
    endproperty
    a_near: assert property (p_near) else $error("near jump wrong");
    property p_far;
        acc && i_opcode == SBJU_OP_JFAR |=> (o_load_cs && o_code_segment == $past(i_imm_seg)
            && o_instruction_pointer == $past(i_imm16)) ##12 s_end;
    endproperty
    a_far: assert property (p_far) else $error("far jump wrong");
    property p_no_push; !o_push_return; endproperty
    a_no_push: assert property (p_no_push) else $error("return info saved");
endmodule // sbju_properties
bind sbju_top sbju_properties u_props (.*);

// ---- sbju_top_tb.sv ----
// self-checking testbench for the signed branch and jump unit
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((e) !== (g)) begin \
    n_errors++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); \
end end
module sbju_top_tb
    import sbju_pkg::*;
;
    // ==========
    // stimulus and observed nets
    logic i_clk = 1'b0, i_rst_n = 1'b0, i_start = 1'b0, i_rm_is_reg = 1'b0, i_bus8 = 1'b0;
    logic i_sign_flag = 1'b0, i_overflow_flag = 1'b0, i_zero_flag = 1'b0;
    logic [7:0] i_opcode = 8'h00;
    logic [2:0] i_reg_field = 3'h0;
    logic [15:0] i_next_ip = 16'h0, i_cur_cs = 16'h1234, i_imm16 = 16'h0, i_imm_seg = 16'h0;
    logic [15:0] i_opnd_off = 16'h0, i_opnd_seg = 16'h0;
    logic o_busy, o_ready, o_done, o_illegal, o_taken, o_load_cs, o_push_return;
    logic [15:0] o_instruction_pointer, o_code_segment;
    int n_errors = 0, samples_checked = 0;
    sbju_top u_dut (.*);
    initial forever #20 i_clk = ~i_clk;
    // md packs {operand in register, 8-bit bus, sign, overflow, zero}
    task automatic run(input logic [7:0] op, input logic [2:0] rf, input logic [4:0] md,
            input logic [15:0] imm, input logic [15:0] seg, input logic [5:0] n_exp,
            input logic [15:0] p_exp);
        logic [5:0] n;
        logic lcs;
        lcs = (op == SBJU_OP_JFAR) || (op == SBJU_OP_GRP && rf == SBJU_REG_FAR_IND);
        @(posedge i_clk);
        #1;
        {i_opcode, i_reg_field, i_start} = {op, rf, 1'b1};
        {i_rm_is_reg, i_bus8, i_sign_flag, i_overflow_flag, i_zero_flag} = md;
        {i_imm16, i_opnd_off, i_imm_seg, i_opnd_seg} = {imm, imm, seg, seg};
        @(posedge i_clk);
        #1;
        i_start = 1'b0;
        `CHK("busy", 1'b1, o_busy)
        n = 6'd2;
        while (o_done !== 1'b1 && n < 6'd40) begin
            @(posedge i_clk);
            #1;
            n = n + 6'd1;
        end
        `CHK("clocks", n_exp, n)
        `CHK("pointer", p_exp, o_instruction_pointer)
        `CHK("segment", lcs ? seg : i_cur_cs, o_code_segment)
        `CHK("taken", n_exp != 6'd4, o_taken)
        `CHK("load_cs", lcs, o_load_cs)
        @(posedge i_clk);
        #1;
        `CHK("done_pulse", 1'b0, o_done)
        `CHK("ready_after", 1'b1, o_ready)
        `CHK("pointer_held", p_exp, o_instruction_pointer)
    endtask
    task automatic t_cond();
        logic [2:0] fl;
        logic t;
        logic [5:0] ne;
        logic [15:0] pe;
        i_next_ip = 16'h0100;
        for (int k = 0; k < 8; k++) begin
            fl = k[2:0];
            t = fl[2] ^ fl[1];
            ne = t ? 6'd13 : 6'd4;
            pe = t ? 16'h0080 : 16'h0100;
            run(SBJU_OP_JLESS, 3'h0, {2'b00, fl}, 16'h5A80, 16'h0, ne, pe);
            t = t | fl[0];
            ne = t ? 6'd13 : 6'd4;
            pe = t ? 16'h017F : 16'h0100;
            run(SBJU_OP_JLEQ, 3'h0, {2'b01, fl}, 16'h007F, 16'h0, ne, pe);
        end
        i_next_ip = 16'hFFF0;
        run(SBJU_OP_JLESS, 3'h0, 5'h04, 16'h0020, 16'h0, 6'd13, 16'h0010);
    endtask
    task automatic t_uncond();
        i_next_ip = 16'h0100;
        run(SBJU_OP_JSHORT, 3'h0, 5'h07, 16'h0080, 16'h0, 6'd14, 16'h0080);
        run(SBJU_OP_JSHORT, 3'h0, 5'h00, 16'h007F, 16'h0, 6'd14, 16'h017F);
        i_next_ip = 16'h9000;
        run(SBJU_OP_JNEAR, 3'h0, 5'h00, 16'h8000, 16'h0, 6'd14, 16'h1000);
        run(SBJU_OP_JFAR, 3'h0, 5'h08, 16'h2345, 16'h6789, 6'd14, 16'h2345);
        run(SBJU_OP_GRP, SBJU_REG_NEAR_IND, 5'h10, 16'hBEEF, 16'h0, 6'd11, 16'hBEEF);
        run(SBJU_OP_GRP, SBJU_REG_NEAR_IND, 5'h00, 16'hBEEF, 16'h0, 6'd17, 16'hBEEF);
        run(SBJU_OP_GRP, SBJU_REG_NEAR_IND, 5'h08, 16'hBEEF, 16'h0, 6'd21, 16'hBEEF);
        run(SBJU_OP_GRP, SBJU_REG_FAR_IND, 5'h00, 16'h1357, 16'h2468, 6'd26, 16'h1357);
        run(SBJU_OP_GRP, SBJU_REG_FAR_IND, 5'h08, 16'h1357, 16'h2468, 6'd34, 16'h1357);
    endtask
    // unhandled codes pulse o_illegal and leave the result alone
    task automatic t_refuse();
        logic [15:0] ip0;
        ip0 = o_instruction_pointer;
        @(posedge i_clk);
        #1;
        {i_opcode, i_reg_field, i_start} = {8'h74, 3'h0, 1'b1};
        @(posedge i_clk);
        #1;
        {i_opcode, i_reg_field} = {SBJU_OP_GRP, 3'h3};
        `CHK("illegal_op", 1'b1, o_illegal)
        `CHK("ready_op", 1'b1, o_ready)
        @(posedge i_clk);
        #1;
        i_start = 1'b0;
        `CHK("illegal_grp", 1'b1, o_illegal)
        `CHK("ip_kept", ip0, o_instruction_pointer)
        @(posedge i_clk);
        #1;
        `CHK("illegal_end", 1'b0, o_illegal)
    endtask
    // start while busy is ignored; reset in mid-instruction returns to idle
    task automatic t_busy_reset();
        @(posedge i_clk);
        #1;
        {i_opcode, i_reg_field, i_start} = {SBJU_OP_JFAR, 3'h0, 1'b1};
        {i_imm16, i_imm_seg} = {16'hA5A5, 16'h5A5A};
        @(posedge i_clk);
        #1;
        i_opcode = SBJU_OP_JNEAR;
        repeat (4) @(posedge i_clk);
        #1;
        i_start = 1'b0;
        `CHK("busy_ignore_ip", 16'hA5A5, o_instruction_pointer)
        `CHK("busy_ignore_cs", 16'h5A5A, o_code_segment)
        `CHK("busy_mid", 1'b1, o_busy)
        i_rst_n = 1'b0;
        repeat (2) @(posedge i_clk);
        #1;
        i_rst_n = 1'b1;
        `CHK("rst_ready", 1'b1, o_ready)
        `CHK("rst_done", 1'b0, o_done)
        `CHK("rst_ip", SBJU_RST_IP, o_instruction_pointer)
        `CHK("rst_cs", SBJU_RST_CS, o_code_segment)
        `CHK("rst_load_cs", 1'b0, o_load_cs)
        `CHK("rst_taken", 1'b0, o_taken)
        @(posedge i_clk);
        #1;
        `CHK("rst_idle", 1'b0, o_busy)
        i_next_ip = 16'h9000;
        run(SBJU_OP_JLESS, 3'h0, 5'h04, 16'h00F0, 16'h0, 6'd13, 16'h8FF0);
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge i_clk);
        #1;
        i_rst_n = 1'b1;
        `CHK("reset_pointer", 16'h0000, o_instruction_pointer)
        t_cond();
        t_uncond();
        t_refuse();
        t_busy_reset();
        report_and_stop();
    end
    // whole run is a few hundred clocks, so this only trips on a hang
    initial begin
        #60000;
        n_errors++;
        report_and_stop();
    end
endmodule // sbju_top_tb
